//--- mrr_top.sv
// Mains reconnection release: two reconnect units behind an APB register file.
// Trigger, permit, block and feedback pins come from outside the clock domain;
// the measured voltages and frequency come from logic on pclk.
//
// Function
// R1 - Two reconnect units run side by side, each with its own settings.
// R2 - Each unit takes six decoupling triggers plus digital, logic and link triggers.
// R3 - With the internal source selected, only the measured voltage check counts.
// R4 - With the coupling-point source selected, only the external permit counts.
// R5 - With the combined source selected, both the check and the permit are needed.
// R6 - The internal check passes only while every line voltage is inside its window.
// R7 - With averaging selected, the check uses the one-minute average voltages.
// R8 - Release comes only after voltage and frequency stay good for the settle time.
// R9 - Any excursion clears the settle timer, which restarts from zero on return.
// R10 - Release needs no trigger, a good check, any needed permit and elapsed settle.
// R11 - An asserted block input prevents release.
// R12 - With feedback assigned, release drops once feedback shows reconnection.
// R13 - Outside logic should latch a block on the wide unit on any decoupling trip.
// R14 - Outside logic should clear that latch once the narrow unit releases.
// R15 - Outside logic may OR both release outputs onto one relay.
// R16 - A returning trigger or block drops release at once and clears the timer.
//
// Our own choices: the register addresses and the APB register port.

`timescale 1ns/100ps
`default_nettype none

module mrr_top #(
    parameter int TICK_CYCLES = mrr_pkg::TICK_CYC
) (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [11:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic [mrr_pkg::UNITS*mrr_pkg::DEC_TRIGS-1:0] decouple_trig,
    input  wire logic [mrr_pkg::UNITS*mrr_pkg::AUX_TRIGS-1:0] aux_trig,
    input  wire logic [mrr_pkg::UNITS-1:0]             coupling_point_permit,
    input  wire logic [mrr_pkg::UNITS-1:0]             unit_block,
    input  wire logic [mrr_pkg::UNITS-1:0]             reconnected_fb,
    input  wire logic [mrr_pkg::MEAS_W-1:0]            vll_inst_ab,
    input  wire logic [mrr_pkg::MEAS_W-1:0]            vll_inst_bc,
    input  wire logic [mrr_pkg::MEAS_W-1:0]            vll_inst_ca,
    input  wire logic [mrr_pkg::MEAS_W-1:0]            vll_avg_ab,
    input  wire logic [mrr_pkg::MEAS_W-1:0]            vll_avg_bc,
    input  wire logic [mrr_pkg::MEAS_W-1:0]            vll_avg_ca,
    input  wire logic [mrr_pkg::MEAS_W-1:0]            freq_meas,
    output logic      [mrr_pkg::UNITS-1:0]             reconnect_permit_out
);

    localparam int U  = mrr_pkg::UNITS;
    localparam int D  = mrr_pkg::DEC_TRIGS;
    localparam int A  = mrr_pkg::AUX_TRIGS;
    localparam int MW = mrr_pkg::MEAS_W;
    localparam int PW = mrr_pkg::PIN_W * mrr_pkg::UNITS;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------

    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_s1_r;
    logic [PW-1:0] pin_s2_r;
    logic [PW-1:0] pin_s3_r;
    logic [PW-1:0] pin_q_r;

    assign pin_raw = {reconnected_fb, unit_block, coupling_point_permit, aux_trig,
                      decouple_trig};

    // Three stages; a bit only moves once stages two and three agree, which
    // rejects a single-cycle glitch that slips past the first stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            pin_q_r  <= '0;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_q_r  <= (pin_s2_r & pin_s3_r) | (pin_q_r & (pin_s2_r ^ pin_s3_r));
        end
    end

    logic [U*D-1:0] dec_q;
    logic [U*A-1:0] aux_q;
    logic [U-1:0]   permit_q;
    logic [U-1:0]   block_q;
    logic [U-1:0]   fb_q;

    assign {fb_q, block_q, permit_q, aux_q, dec_q} = pin_q_r;

    // ------------------------------------------------------------------
    // Millisecond tick for the settle timers
    // ------------------------------------------------------------------

    logic [31:0] tick_cnt_r;
    logic        tick;

    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    // One shared divider; both units see the same tick, so a settle time is
    // exact to within one tick of jitter at its start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // APB access decode
    // ------------------------------------------------------------------

    logic                     wr_en;
    logic [U-1:0]             unit_sel;
    logic [4:0]               reg_ofs;
    logic [mrr_pkg::CTRL_W-1:0] ctrl_r   [U];
    logic [MW-1:0]            vlo_r    [U];
    logic [MW-1:0]            vhi_r    [U];
    logic [MW-1:0]            flo_r    [U];
    logic [MW-1:0]            fhi_r    [U];
    logic [MW-1:0]            settle_r [U];
    logic [MW-1:0]            cnt_r    [U];
    logic [31:0]              status   [U];

    assign pready  = 1'b1;                     // Every access completes in one cycle.
    assign wr_en   = psel && penable && pwrite;
    assign reg_ofs = paddr[4:0];

    // Read mux and error answer; unmapped or unaligned addresses read zero
    // and flag pslverr, and a write there is dropped.
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr[1:0] != 2'b00 || paddr >= 12'(U) * mrr_pkg::UNIT_STRIDE) begin
            pslverr = psel && penable;
        end else if (reg_ofs == mrr_pkg::OFS_CTRL) begin
            prdata = 32'(ctrl_r[paddr[5]]);
        end else if (reg_ofs == mrr_pkg::OFS_VLO) begin
            prdata = 32'(vlo_r[paddr[5]]);
        end else if (reg_ofs == mrr_pkg::OFS_VHI) begin
            prdata = 32'(vhi_r[paddr[5]]);
        end else if (reg_ofs == mrr_pkg::OFS_FLO) begin
            prdata = 32'(flo_r[paddr[5]]);
        end else if (reg_ofs == mrr_pkg::OFS_FHI) begin
            prdata = 32'(fhi_r[paddr[5]]);
        end else if (reg_ofs == mrr_pkg::OFS_SETTLE) begin
            prdata = 32'(settle_r[paddr[5]]);
        end else if (reg_ofs == mrr_pkg::OFS_STATUS) begin
            prdata = status[paddr[5]];
        end else begin
            pslverr = psel && penable;
        end
    end

    // ------------------------------------------------------------------
    // Reconnect units
    // ------------------------------------------------------------------

    for (genvar u = 0; u < U; u++) begin : g_unit // R1
        logic                ok_wr;
        logic [D-1:0]        dec_mask;
        logic [A-1:0]        aux_mask;
        logic [1:0]          cond;
        logic                trig_act;
        logic                hold;
        logic [MW-1:0]       v_ab;
        logic [MW-1:0]       v_bc;
        logic [MW-1:0]       v_ca;
        logic                v_int_ok;
        logic                v_ok;
        logic                f_ok;
        logic                good;
        mrr_pkg::mrr_state_t state_r;
        mrr_pkg::mrr_state_t state_nxt;

        assign unit_sel[u] = (paddr[11:5] == 7'(u));
        assign ok_wr       = wr_en && unit_sel[u] && (paddr[1:0] == 2'b00);

        // Software settings of this unit.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctrl_r[u]   <= mrr_pkg::CTRL_RST;
                vlo_r[u]    <= mrr_pkg::VLO_RST;
                vhi_r[u]    <= mrr_pkg::VHI_RST;
                flo_r[u]    <= mrr_pkg::FLO_RST;
                fhi_r[u]    <= mrr_pkg::FHI_RST;
                settle_r[u] <= mrr_pkg::SETTLE_RST;
            end else if (ok_wr) begin
                if (reg_ofs == mrr_pkg::OFS_CTRL) begin
                    ctrl_r[u] <= pwdata[mrr_pkg::CTRL_W-1:0];
                end else if (reg_ofs == mrr_pkg::OFS_VLO) begin
                    vlo_r[u] <= pwdata[MW-1:0];
                end else if (reg_ofs == mrr_pkg::OFS_VHI) begin
                    vhi_r[u] <= pwdata[MW-1:0];
                end else if (reg_ofs == mrr_pkg::OFS_FLO) begin
                    flo_r[u] <= pwdata[MW-1:0];
                end else if (reg_ofs == mrr_pkg::OFS_FHI) begin
                    fhi_r[u] <= pwdata[MW-1:0];
                end else if (reg_ofs == mrr_pkg::OFS_SETTLE) begin
                    settle_r[u] <= pwdata[MW-1:0];
                end
            end
        end

        assign dec_mask = ctrl_r[u][mrr_pkg::CTRL_TRIG_LSB +: D];
        assign aux_mask = ctrl_r[u][mrr_pkg::CTRL_AUX_LSB +: A];
        assign cond     = ctrl_r[u][mrr_pkg::CTRL_COND_LSB +: 2];

        // Any enabled trigger, from a decoupling function or an auxiliary source.
        assign trig_act = |(dec_q[u*D +: D] & dec_mask) | |(aux_q[u*A +: A] & aux_mask); // R2
        assign hold     = trig_act || block_q[u]; // R11

        // Voltage source: averaged values are steadier but react a minute late.
        assign v_ab = ctrl_r[u][mrr_pkg::CTRL_AVG_BIT] ? vll_avg_ab : vll_inst_ab; // R7
        assign v_bc = ctrl_r[u][mrr_pkg::CTRL_AVG_BIT] ? vll_avg_bc : vll_inst_bc; // R7
        assign v_ca = ctrl_r[u][mrr_pkg::CTRL_AVG_BIT] ? vll_avg_ca : vll_inst_ca; // R7

        // All three line voltages must sit inside the line_voltage_window.
        assign v_int_ok = (v_ab >= vlo_r[u]) && (v_ab <= vhi_r[u]) &&
                          (v_bc >= vlo_r[u]) && (v_bc <= vhi_r[u]) &&
                          (v_ca >= vlo_r[u]) && (v_ca <= vhi_r[u]); // R6
        assign f_ok     = (freq_meas >= flo_r[u]) && (freq_meas <= fhi_r[u]);

        // Permit source select; the unused encoding behaves as internal.
        always_comb begin
            case (cond)
                mrr_pkg::COND_PCC:  v_ok = permit_q[u];              // R4
                mrr_pkg::COND_BOTH: v_ok = v_int_ok && permit_q[u];  // R5
                default:            v_ok = v_int_ok;                 // R3
            endcase
        end

        assign good = v_ok && f_ok && !hold; // R10

        // Release sequence.
        always_comb begin
            state_nxt = state_r;
            case (state_r)
                mrr_pkg::MRR_IDLE: begin
                    if (good) begin
                        state_nxt = mrr_pkg::MRR_SETTLE;
                    end
                end
                mrr_pkg::MRR_SETTLE: begin
                    if (!good) begin
                        state_nxt = mrr_pkg::MRR_IDLE; // R9
                    end else if (cnt_r[u] >= settle_r[u]) begin
                        state_nxt = mrr_pkg::MRR_RELEASED; // R8
                    end
                end
                mrr_pkg::MRR_RELEASED: begin
                    if (!good) begin
                        state_nxt = mrr_pkg::MRR_IDLE; // R16
                    end else if (ctrl_r[u][mrr_pkg::CTRL_FB_BIT] && fb_q[u]) begin
                        state_nxt = mrr_pkg::MRR_RECONN; // R12
                    end
                end
                default: begin
                    if (!good || !fb_q[u] || !ctrl_r[u][mrr_pkg::CTRL_FB_BIT]) begin
                        state_nxt = mrr_pkg::MRR_IDLE;
                    end
                end
            endcase
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                state_r <= mrr_pkg::MRR_IDLE;
            end else begin
                state_r <= state_nxt;
            end
        end

        // Settle timer counts only ticks after entry to settling, so a settle time
        // never runs short by a tick that falls on the entry edge; it saturates.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_r[u] <= '0;
            end else if (state_nxt != mrr_pkg::MRR_SETTLE) begin
                cnt_r[u] <= '0; // R9
            end else if (tick && state_r == mrr_pkg::MRR_SETTLE && cnt_r[u] != {MW{1'b1}}) begin
                cnt_r[u] <= cnt_r[u] + 16'h0001; // R8
            end
        end

        // Release output from its own flop.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                reconnect_permit_out[u] <= 1'b0;
            end else begin
                reconnect_permit_out[u] <= (state_nxt == mrr_pkg::MRR_RELEASED); // R10
            end
        end

        assign status[u] = {cnt_r[u], 8'h00, 2'b00, state_r, trig_act, block_q[u],
                            v_ok, f_ok};
    end : g_unit

endmodule : mrr_top

`default_nettype wire

//--- mrr_pkg.sv
// Package for the mains reconnection release block: register map, field positions,
// reset values, unit states and timing constants.
// Assumes a 200 MHz APB clock and one settle-timer tick per millisecond.

package mrr_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int UNITS      = 2;       // Independent reconnect units.
    localparam int DEC_TRIGS  = 6;       // Decoupling function triggers per unit.
    localparam int AUX_TRIGS  = 3;       // Digital input, logic equation, supervisory link.
    localparam int MEAS_W     = 16;      // Width of a measured value.
    localparam int PIN_W      = 12;      // Pins per unit: 6 + 3 + permit + block + feedback.

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ    = 200;     // Clock rate in MHz.
    localparam int TICK_US    = 1000;    // Settle timer resolution in microseconds.
    localparam int TICK_CYC   = TICK_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // Register map, byte addresses within one unit, and unit stride
    // ------------------------------------------------------------------
    localparam logic [11:0] UNIT_STRIDE = 12'h020;
    localparam logic [4:0]  OFS_CTRL    = 5'h00;
    localparam logic [4:0]  OFS_VLO     = 5'h04;
    localparam logic [4:0]  OFS_VHI     = 5'h08;
    localparam logic [4:0]  OFS_FLO     = 5'h0c;
    localparam logic [4:0]  OFS_FHI     = 5'h10;
    localparam logic [4:0]  OFS_SETTLE  = 5'h14;
    localparam logic [4:0]  OFS_STATUS  = 5'h18;

    // Control register fields.
    localparam int CTRL_TRIG_LSB = 0;    // 6-bit decoupling trigger enable mask.
    localparam int CTRL_AUX_LSB  = 6;    // 3-bit auxiliary trigger enable mask.
    localparam int CTRL_COND_LSB = 9;    // 2-bit permit source select.
    localparam int CTRL_AVG_BIT  = 11;   // Use averaged voltages.
    localparam int CTRL_FB_BIT   = 12;   // Reconnected feedback assigned.
    localparam int CTRL_W        = 13;

    // Permit source select encodings.
    localparam logic [1:0] COND_INTERNAL = 2'h0;
    localparam logic [1:0] COND_PCC      = 2'h1;
    localparam logic [1:0] COND_BOTH     = 2'h2;

    // Reset values.
    localparam logic [CTRL_W-1:0] CTRL_RST   = 13'h0000;
    localparam logic [MEAS_W-1:0] VLO_RST    = 16'h0000;
    localparam logic [MEAS_W-1:0] VHI_RST    = 16'hffff;
    localparam logic [MEAS_W-1:0] FLO_RST    = 16'h0000;
    localparam logic [MEAS_W-1:0] FHI_RST    = 16'hffff;
    localparam logic [MEAS_W-1:0] SETTLE_RST = 16'h0000;

    // Unit states, Gray coded along idle, settle, released, reconnected.
    typedef enum logic [1:0] {
        MRR_IDLE     = 2'b00,
        MRR_SETTLE   = 2'b01,
        MRR_RELEASED = 2'b11,
        MRR_RECONN   = 2'b10
    } mrr_state_t;

endpackage : mrr_pkg

//--- mrr_monitor.sv
// Checker for the reconnection release block, bound to every mrr_top.
// Assumes zero-wait APB and active-high, synchronised unit block pins.
`timescale 1ns/100ps
`default_nettype none
module mrr_monitor #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [11:0]                 paddr,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [mrr_pkg::UNITS-1:0]   unit_block,
    input wire logic [mrr_pkg::UNITS-1:0]   reconnect_permit_out
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access phase flag; the pin filter needs six cycles before a block must show.
    logic acc;
    assign acc = psel && penable;
    sequence blk_held_s(b);
        b [*6];
    endsequence

    pready_high_a: assert property (pready) else $error("pready low");
    idle_no_err_a: assert property (!acc |-> !pslverr) else $error("error outside access");
    high_addr_err_a: assert property (acc && paddr >= 12'h040 |-> pslverr)
        else $error("high address accepted");
    unaligned_err_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned address accepted");
    hole_addr_err_a: assert property (acc && paddr[4:2] == 3'h7 |-> pslverr)
        else $error("unused offset accepted");
    mapped_ok_a: assert property (acc && paddr < 12'h040 && paddr[1:0] == 2'h0
        && paddr[4:2] != 3'h7 |-> !pslverr) else $error("mapped address refused");
    err_reads_zero_a: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    block_holds0_a: assert property (blk_held_s(unit_block[0]) |-> !reconnect_permit_out[0])
        else $error("unit 0 released while blocked");
    block_holds1_a: assert property (blk_held_s(unit_block[1]) |-> !reconnect_permit_out[1])
        else $error("unit 1 released while blocked");
    block_drop_a: assert property (reconnect_permit_out[0] && $rose(unit_block[0])
        |-> ##[1:5] !reconnect_permit_out[0]) else $error("release not dropped on block");
endmodule : mrr_monitor

bind mrr_top mrr_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_block(unit_block),
    .reconnect_permit_out(reconnect_permit_out));
`default_nettype wire

//--- mrr_partner.sv
// Model of the protection and breaker control logic around the two units.
// Assumes unit 0 is the narrow unit and unit 1 the wide one.
`timescale 1ns/100ps
`default_nettype none
module mrr_partner (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] decouple_trig,
    input wire logic [1:0]  reconnect_permit_out,
    input wire logic [1:0]  ext_block,
    input wire logic        close_en,
    output logic     [1:0]  unit_block,
    output logic     [1:0]  reconnected_fb,
    output logic            relay
);
    // ------------------------------------------------------------------
    // Latch and breaker
    // ------------------------------------------------------------------
    logic wide_blk_r;
    logic closed_r;

    // Set wins over clear so a trip during a release still blocks the wide unit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wide_blk_r <= 1'h0;
        else if (|decouple_trig) wide_blk_r <= 1'h1;
        else if (reconnect_permit_out[0]) wide_blk_r <= 1'h0;
    end

    // The breaker closes one cycle after the relay when closing is allowed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) closed_r <= 1'h0;
        else closed_r <= close_en && relay;
    end

    // Relay output, and outputs towards the units.
    assign relay = |reconnect_permit_out;
    assign unit_block = {wide_blk_r | ext_block[1], ext_block[0]};
    assign reconnected_fb = {closed_r, closed_r};
endmodule : mrr_partner
`default_nettype wire

//--- mrr_top_tb.sv
// Self-checking bench for mrr_top with the partner model on its pins.
// Assumes a settle tick every four cycles and zero-wait APB.
`timescale 1ns/100ps
`default_nettype none
module mrr_top_tb;
    // ------------------------------------------------------------------
    // Signals and rows
    // ------------------------------------------------------------------
    localparam int TK = 4;
    localparam logic [15:0] VIN = 16'h0180, VOUT = 16'h0300, FIN = 16'h1800, FOUT = 16'h3000;
    typedef struct packed {logic [1:0] cond; logic avg, vi, va, pm, ex;} mrr_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, close_en, relay;
    logic [11:0] paddr, dtrig;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  atrig;
    logic [1:0]  permit, blk, fb, outp, xblk;
    logic [15:0] vab, vbc, vca, aab, abc, aca, freq;
    int          n_errors, num_checks, cycles, k;
    // Source select, average, inst ok, avg ok, permit, expected release.
    mrr_row_t rows [10] = '{'{2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1},
        '{2'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0}, '{2'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1},
        '{2'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0}, '{2'h2, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1},
        '{2'h2, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0}, '{2'h2, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0},
        '{2'h3, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1}, '{2'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
        '{2'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0}};
    // Address, read value and error flag after a fresh reset.
    logic [44:0] regs [7] = '{{12'h000, 32'h0, 1'h0}, {12'h008, 32'hffff, 1'h0},
        {12'h010, 32'hffff, 1'h0}, {12'h014, 32'h0, 1'h0}, {12'h024, 32'h0, 1'h0},
        {12'h01c, 32'h0, 1'h1}, {12'h040, 32'h0, 1'h1}};

    mrr_top #(.TICK_CYCLES(TK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .decouple_trig(dtrig), .aux_trig(atrig),
        .coupling_point_permit(permit), .unit_block(blk), .reconnected_fb(fb),
        .vll_inst_ab(vab), .vll_inst_bc(vbc), .vll_inst_ca(vca), .vll_avg_ab(aab),
        .vll_avg_bc(abc), .vll_avg_ca(aca), .freq_meas(freq), .reconnect_permit_out(outp));
    mrr_partner u_part (.pclk(pclk), .presetn(presetn), .decouple_trig(dtrig),
        .reconnect_permit_out(outp), .ext_block(xblk), .close_en(close_en),
        .unit_block(blk), .reconnected_fb(fb), .relay(relay));

    // Clock and a hang guard well above the expected run length.
    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // One APB transfer; the request stays put until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_cyc
    // Three ticks of settle time, plus pin filter slack, bound the release moment.
    task automatic timed(input string nm);
        int c;
        c = 0;
        while (outp[0] !== 1'h1 && c < 100) begin
            @(posedge pclk);
            c++;
        end
        check(nm, 32'(c >= 10 && c <= 22), 32'h1);
        $display("test %s done", nm);
    endtask : timed
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, dtrig, atrig} = '0;
        {permit, xblk, close_en, n_errors, num_checks, cycles} = '0;
        {vab, vbc, vca, aab, abc, aca, freq} = {VIN, VIN, VIN, VIN, VIN, VIN, FIN};
        wait_cyc(2);
        presetn <= 1'h1;
        apb(1'h1, 12'h004, 32'h0100);
        apb(1'h1, 12'h008, 32'h0200);
        apb(1'h1, 12'h00c, 32'h1000);
        apb(1'h1, 12'h010, 32'h2000);
        apb(1'h1, 12'h014, 32'h1);
        for (k = 0; k < 10; k++) begin
            apb(1'h1, 12'h000, {20'h0, rows[k].avg, rows[k].cond, 9'h0});
            vca <= rows[k].vi ? VIN : VOUT;
            {aab, abc, aca} <= rows[k].va ? {VIN, VIN, VIN} : {VOUT, VOUT, VOUT};
            permit[0] <= rows[k].pm;
            wait_cyc(30);
            check("row release", outp[0], rows[k].ex);
            $display("test row %0d done", k);
        end
        apb(1'h1, 12'h000, 32'h0);
        vca <= VIN;
        freq <= FOUT;
        apb(1'h1, 12'h014, 32'h3);
        freq <= FIN;
        timed("settle");
        freq <= FOUT;
        wait_cyc(4);
        freq <= FIN;
        wait_cyc(8);
        freq <= FOUT;
        @(posedge pclk);
        freq <= FIN;
        timed("restart");
        xblk[0] <= 1'h1;
        wait_cyc(8);
        check("blocked", outp[0], 1'h0);
        xblk[0] <= 1'h0;
        timed("unblock");
        apb(1'h1, 12'h014, 32'h0);
        apb(1'h1, 12'h000, 32'h1ff);
        for (k = 0; k < 9; k++) begin
            if (k < 6) dtrig[k] <= 1'h1;
            else atrig[k-6] <= 1'h1;
            wait_cyc(8);
            check("trip", outp, (k < 6) ? 2'h0 : 2'h2);
            dtrig <= '0;
            atrig <= '0;
            wait_cyc(16);
            check("recover", outp, 2'h3);
        end
        $display("test triggers done");
        apb(1'h1, 12'h000, 32'h1000);
        close_en <= 1'h1;
        wait_cyc(10);
        check("feedback", outp, 2'h2);
        close_en <= 1'h0;
        presetn <= 1'h0;
        wait_cyc(2);
        check("reset out", outp, 2'h0);
        presetn <= 1'h1;
        for (k = 0; k < 7; k++) begin
            apb(1'h0, regs[k][44:33], 32'h0);
            check("reg data", rd, regs[k][32:1]);
            check("reg error", er, regs[k][0]);
        end
        apb(1'h1, 12'h002, 32'h1);
        check("unaligned", er, 1'h1);
        $display("test registers done");
        tally_and_finish();
    end
endmodule : mrr_top_tb
`default_nettype wire
